// file: inc/opaddr_pkg.sv
// Behaviour
// - seventeen modes in seven families
// - inherent: one byte, no operand fetch
// - immediate: next byte is operand value
// - short direct and short indirect forms reach page zero only; short indexed reaches up to 01feh
// - read-modify-write accepts short forms only
// - short direct: one byte, zero-extended
// - long direct: two address bytes
// - index plus offset added unsigned
// - no-offset indexed: index is address
// - short indexed: byte offset plus index
// - long indexed: word offset plus index
// - indirect: read pointer, then use it
// - short indirect: byte pointer in page zero
// - long indirect: word pointer in page zero
// - indirect indexed: pointer plus index unsigned
// - relative: signed 8-bit displacement to PC
// - second index prefix selects second index
// - indirect conversion prefix makes indirect forms
// - indirect second index prefix selects second index
package opaddr_pkg;

  // ****************************************
  // addressing modes, 17 of them
  // ****************************************
  typedef enum logic [4:0] {
    M_INH      = 5'h00,
    M_IMM      = 5'h01,
    M_DIR_S    = 5'h02,
    M_DIR_L    = 5'h03,
    M_IDX_0    = 5'h04,
    M_IDX_S    = 5'h05,
    M_IDX_L    = 5'h06,
    M_IND_S    = 5'h07,
    M_IND_L    = 5'h08,
    M_INDX_S   = 5'h09,
    M_INDX_L   = 5'h0a,
    M_REL_D    = 5'h0b,
    M_REL_I    = 5'h0c,
    M_BIT_D    = 5'h0d,
    M_BIT_I    = 5'h0e,
    M_BITREL_D = 5'h0f,
    M_BITREL_I = 5'h10
  } addr_mode_t;

  // mode families
  typedef enum logic [2:0] {
    F_INHERENT  = 3'h0,
    F_IMMEDIATE = 3'h1,
    F_DIRECT    = 3'h2,
    F_INDEXED   = 3'h3,
    F_INDIRECT  = 3'h4,
    F_RELATIVE  = 3'h5,
    F_BIT       = 3'h6
  } mode_family_t;

  // prefix byte values
  localparam logic [7:0] SECOND_INDEX_PREFIX          = 8'h90;
  localparam logic [7:0] INDIRECT_CONVERSION_PREFIX   = 8'h92;
  localparam logic [7:0] INDIRECT_SECOND_INDEX_PREFIX = 8'h91;

  localparam logic [15:0] RESET_ADDR = 16'h0000;
  localparam logic [7:0]  RESET_BYTE = 8'h00;

  // mode to family; used by the decoder and available to the core
  function automatic mode_family_t family_of(input addr_mode_t m);
    case (m)
      M_INH:                                  family_of = F_INHERENT;
      M_IMM:                                  family_of = F_IMMEDIATE;
      M_DIR_S, M_DIR_L:                       family_of = F_DIRECT;
      M_IDX_0, M_IDX_S, M_IDX_L:              family_of = F_INDEXED;
      M_IND_S, M_IND_L, M_INDX_S, M_INDX_L:   family_of = F_INDIRECT;
      M_REL_D, M_REL_I:                       family_of = F_RELATIVE;
      default:                                family_of = F_BIT;
    endcase
  endfunction

endpackage

// file: hdl/prefix_mapper.sv
`timescale 1ns/10ps
module prefix_mapper
  import opaddr_pkg::*;
(
  input  addr_mode_t baseMode,     // mode named by the opcode
  input  wire logic  prefixValid,  // a prefix byte preceded the opcode
  input  wire logic [7:0] prefix,  // that prefix byte
  output addr_mode_t mode,         // mode after prefix conversion
  output logic       useSecond,    // index from second index register
  output logic       illegal       // prefix cannot apply to this mode
);

  always_comb begin
    mode      = baseMode;
    useSecond = 1'b0;
    illegal   = 1'b0;
    if (prefixValid) begin
      case (prefix)
        SECOND_INDEX_PREFIX: begin
          useSecond = 1'b1;
        end
        INDIRECT_CONVERSION_PREFIX: begin
          case (baseMode)
            M_DIR_S:    mode = M_IND_S;
            M_DIR_L:    mode = M_IND_L;
            M_IDX_S:    mode = M_INDX_S;
            M_IDX_L:    mode = M_INDX_L;
            M_REL_D:    mode = M_REL_I;
            M_BIT_D:    mode = M_BIT_I;
            M_BITREL_D: mode = M_BITREL_I;
            default:    illegal = 1'b1;
          endcase
        end
        INDIRECT_SECOND_INDEX_PREFIX: begin
          useSecond = 1'b1;
          case (baseMode)
            M_IDX_S: mode = M_INDX_S;
            M_IDX_L: mode = M_INDX_L;
            default: illegal = 1'b1;
          endcase
        end
        default: illegal = 1'b1;
      endcase
    end
  end

endmodule // prefix_mapper

// file: hdl/operand_addr_decoder.sv
`timescale 1ns/10ps
module operand_addr_decoder
  import opaddr_pkg::*;
(
  input  wire logic        mclk,         // cpu clock
  input  wire logic        rst,          // synchronous reset, high
  input  wire logic        start,        // pulse: decode a new instruction
  input  addr_mode_t       baseMode,     // mode named by the opcode
  input  wire logic        prefixValid,  // prefix byte present
  input  wire logic [7:0]  prefix,       // prefix byte value
  input  wire logic        rmwOp,        // opcode is read-modify-write
  input  wire logic [2:0]  bitField,     // bit number from opcode
  input  wire logic [15:0] opcodePc,     // address of the opcode byte
  input  wire logic [7:0]  indexX,       // first index register
  input  wire logic [7:0]  indexY,       // second index register
  output logic             memRead,      // pulse: read request
  output logic [15:0]      memAddr,      // read address
  input  wire logic        memValid,     // pulse: read data valid
  input  wire logic [7:0]  memData,      // read data
  output logic             done,         // pulse: results valid
  output logic             busy,         // decode in progress
  output logic             badMode,      // sticky per instruction: illegal form
  output addr_mode_t       modeOut,      // resolved mode
  output mode_family_t     familyOut,    // its family
  output logic [2:0]       instLen,      // bytes after the opcode
  output logic [15:0]      effAddr,      // effective address
  output logic [7:0]       immValue,     // immediate operand value
  output logic             isImmediate,  // operand is immediate
  output logic [2:0]       bitSel,       // selected bit
  output logic [15:0]      branchTarget  // pc relative target
);

  // ****************************************
  // fetch sequencer
  // ****************************************
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_REQ  = 3'b001,
    S_WAIT = 3'b010,
    S_DONE = 3'b011
  } state_t;

  // what each fetched byte is for
  typedef enum logic [2:0] {
    B_OPND_HI = 3'b000,  // address/offset high or only byte
    B_OPND_LO = 3'b001,
    B_PTR_HI  = 3'b010,  // pointer byte(s) read from page zero
    B_PTR_LO  = 3'b011,
    B_DISP    = 3'b100,  // relative displacement from stream
    B_DISP_IN = 3'b101   // displacement read through pointer
  } step_t;

  addr_mode_t   mode;
  logic         useSecond;
  logic         prefixBad;

  prefix_mapper u_map (
    .baseMode    (baseMode),
    .prefixValid (prefixValid),
    .prefix      (prefix),
    .mode        (mode),
    .useSecond   (useSecond),
    .illegal     (prefixBad)
  );

  state_t       state, next_state;
  step_t        step, next_step;
  addr_mode_t   curMode, next_curMode;
  logic [7:0]   idx, next_idx;
  logic [15:0]  pc, next_pc;
  logic [15:0]  streamAddr, next_streamAddr;
  logic [15:0]  opnd, next_opnd;
  logic [15:0]  ptrAddr, next_ptrAddr;
  logic [7:0]   disp, next_disp;
  logic [2:0]   bitReg, next_bitReg;
  logic         bad, next_bad;
  logic         next_memRead;
  logic [15:0]  next_memAddr;
  logic         next_done;
  logic [15:0]  next_effAddr;
  logic [15:0]  next_branch;

  // number of bytes after the opcode for a mode
  function automatic logic [2:0] length_of(input addr_mode_t m);
    case (m)
      M_INH, M_IDX_0:                       length_of = 3'h0;
      M_DIR_L, M_IDX_L,
      M_BITREL_D, M_BITREL_I:               length_of = 3'h2;
      default:                              length_of = 3'h1;
    endcase
  endfunction

  // count of operand bytes taken from the instruction stream; gives 1 for M_BITREL_I, which takes 2
  function automatic logic [1:0] stream_bytes(input addr_mode_t m);
    case (m)
      M_INH, M_IDX_0:                       stream_bytes = 2'h0;
      M_DIR_L, M_IDX_L, M_BITREL_D:         stream_bytes = 2'h2;
      default:                              stream_bytes = 2'h1;
    endcase
  endfunction
  function automatic logic [15:0] add_index(input logic [15:0] b, input logic [7:0] i);
    add_index = b + {8'h00, i};
  endfunction

  // two-byte stream operand; long direct and long indexed start with the high byte
  function automatic logic long_stream(input addr_mode_t m);
    long_stream = (m == M_DIR_L) || (m == M_IDX_L);
  endfunction

  always_comb begin
    next_state      = state;
    next_step       = step;
    next_curMode    = curMode;
    next_idx        = idx;
    next_pc         = pc;
    next_streamAddr = streamAddr;
    next_opnd       = opnd;
    next_ptrAddr    = ptrAddr;
    next_disp       = disp;
    next_bitReg     = bitReg;
    next_bad        = bad;
    next_memRead    = 1'b0;
    next_memAddr    = memAddr;
    next_done       = 1'b0;
    next_effAddr    = effAddr;
    next_branch     = branchTarget;
    case (state)
      S_IDLE: begin
        if (start) begin
          next_curMode    = mode;
          next_idx        = useSecond ? indexY : indexX;
          next_pc         = opcodePc;
          next_streamAddr = opcodePc + 16'h0001;
          next_opnd       = RESET_ADDR;
          next_disp       = RESET_BYTE;
          next_bitReg     = bitField;
          next_bad        = prefixBad ||
                            (rmwOp && (mode inside {M_DIR_L, M_IDX_L, M_IND_L, M_INDX_L}));
          next_step       = B_OPND_HI;
          next_state      = (stream_bytes(mode) == 2'h0) ? S_DONE : S_REQ;
        end
      end
      S_REQ: begin
        next_memRead = 1'b1;
        case (step)
          B_PTR_HI, B_PTR_LO, B_DISP_IN: next_memAddr = ptrAddr;
          default:                       next_memAddr = streamAddr;
        endcase
        next_state = S_WAIT;
      end
      S_WAIT: begin
        if (memValid) begin
          next_state = S_REQ;
          case (step)
            B_OPND_HI: begin
              next_streamAddr = streamAddr + 16'h0001;
              if (long_stream(curMode)) begin
                next_opnd = {memData, 8'h00};
                next_step = B_OPND_LO;
              end else begin
                next_opnd    = {8'h00, memData};
                next_ptrAddr = {8'h00, memData};
                next_disp    = (curMode == M_REL_D) ? memData : disp;
                case (curMode)
                  M_IND_S, M_IND_L, M_INDX_S,
                  M_INDX_L, M_BIT_I, M_BITREL_I: next_step = B_PTR_HI;
                  M_REL_I:                       next_step = B_DISP_IN;
                  M_BITREL_D:                    next_step = B_DISP;
                  default:                       next_state = S_DONE;
                endcase
              end
            end
            B_OPND_LO: begin
              next_streamAddr = streamAddr + 16'h0001;
              next_opnd       = {opnd[15:8], memData};
              next_state      = S_DONE;
            end
            B_PTR_HI: begin
              next_ptrAddr = ptrAddr + 16'h0001;
              if (curMode == M_IND_L || curMode == M_INDX_L) begin
                next_opnd = {memData, 8'h00};
                next_step = B_PTR_LO;
              end else begin
                next_opnd = {8'h00, memData};
                if (curMode == M_BITREL_I)
                  next_step = B_DISP;
                else
                  next_state = S_DONE;
              end
            end
            B_PTR_LO: begin
              next_opnd  = {opnd[15:8], memData};
              next_state = S_DONE;
            end
            default: begin
              next_disp       = memData;
              next_streamAddr = streamAddr + 16'h0001;
              next_state      = S_DONE;
            end
          endcase
        end
      end
      S_DONE: begin
        next_done  = 1'b1;
        next_state = S_IDLE;
        case (curMode)
          M_IDX_0:                    next_effAddr = {8'h00, idx};
          M_IDX_S, M_IDX_L,
          M_INDX_S, M_INDX_L:         next_effAddr = add_index(opnd, idx);
          default:                    next_effAddr = opnd;
        endcase
        next_branch = pc + 16'h0001 + {13'h0000, length_of(curMode)}
                      + {{8{disp[7]}}, disp};
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state        <= S_IDLE;
      step         <= B_OPND_HI;
      curMode      <= M_INH;
      idx          <= RESET_BYTE;
      pc           <= RESET_ADDR;
      streamAddr   <= RESET_ADDR;
      opnd         <= RESET_ADDR;
      ptrAddr      <= RESET_ADDR;
      disp         <= RESET_BYTE;
      bitReg       <= 3'h0;
      bad          <= 1'b0;
      memRead      <= 1'b0;
      memAddr      <= RESET_ADDR;
      done         <= 1'b0;
      effAddr      <= RESET_ADDR;
      branchTarget <= RESET_ADDR;
    end else begin
      state        <= next_state;
      step         <= next_step;
      curMode      <= next_curMode;
      idx          <= next_idx;
      pc           <= next_pc;
      streamAddr   <= next_streamAddr;
      opnd         <= next_opnd;
      ptrAddr      <= next_ptrAddr;
      disp         <= next_disp;
      bitReg       <= next_bitReg;
      bad          <= next_bad;
      memRead      <= next_memRead;
      memAddr      <= next_memAddr;
      done         <= next_done;
      effAddr      <= next_effAddr;
      branchTarget <= next_branch;
    end
  end

  // ****************************************
  // result registers
  // ****************************************
  // mode and family
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy        <= 1'b0;
      badMode     <= 1'b0;
      modeOut     <= M_INH;
      familyOut   <= F_INHERENT;
      instLen     <= 3'h0;
      immValue    <= RESET_BYTE;
      isImmediate <= 1'b0;
      bitSel      <= 3'h0;
    end else begin
      busy <= (next_state != S_IDLE);
      if (state == S_DONE) begin
        badMode     <= bad;
        modeOut     <= curMode;
        familyOut   <= family_of(curMode);
        instLen     <= length_of(curMode);
        immValue    <= opnd[7:0];
        isImmediate <= (curMode == M_IMM);
        bitSel      <= bitReg;
      end
    end
  end

endmodule // operand_addr_decoder

// file: sim/opaddr_props.sv
`timescale 1ns/10ps
module opaddr_props
  import opaddr_pkg::*;
(
  input wire logic        mclk,         // cpu clock
  input wire logic        rst,          // sync reset
  input wire logic        start,        // decode request
  input addr_mode_t       baseMode,     // opcode mode
  input wire logic        prefixValid,  // prefix present
  input wire logic        memRead,      // read request
  input wire logic        memValid,     // read answer
  input wire logic        done,         // results valid
  input wire logic        busy,         // decode running
  input addr_mode_t       modeOut,      // resolved mode
  input mode_family_t     familyOut,    // its family
  input wire logic [2:0]  instLen,      // bytes after opcode
  input wire logic [15:0] effAddr,      // effective address
  input wire logic [7:0]  immValue,     // immediate value
  input wire logic        isImmediate   // immediate flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_take;
    start && !busy && !done;
  endsequence
  sequence s_noFetch;
    !memRead ##1 (done && !memRead);
  endsequence

  property p_inhNoFetch;
    s_take ##0 (baseMode == M_INH && !prefixValid) |-> ##1 s_noFetch;
  endproperty
  property p_idx0;
    done && modeOut == M_IDX_0 |-> instLen == 3'h0 && effAddr[15:8] == 8'h00;
  endproperty
  property p_imm;
    done && modeOut == M_IMM |-> isImmediate && instLen == 3'h1 && effAddr == {8'h00, immValue};
  endproperty
  property p_dirShort;
    done && modeOut == M_DIR_S |-> instLen == 3'h1 && effAddr[15:8] == 8'h00;
  endproperty
  property p_longLen;
    done && modeOut inside {M_DIR_L, M_IDX_L} |-> instLen == 3'h2;
  endproperty
  property p_shortReach;
    done && modeOut inside {M_IDX_S, M_INDX_S} |-> effAddr <= 16'h01fe;
  endproperty
  property p_pageZero;
    done && modeOut inside {M_IND_S, M_BIT_D, M_BIT_I, M_BITREL_D, M_BITREL_I}
      |-> effAddr[15:8] == 8'h00;
  endproperty
  property p_fetchPace;
    memValid && busy |-> ##2 (memRead || done);
  endproperty
  property p_family;
    done && modeOut inside {M_IND_S, M_IND_L, M_INDX_S, M_INDX_L} |-> familyOut == F_INDIRECT;
  endproperty

  a_inhNoFetch: assert property (p_inhNoFetch) else $error("inherent decode fetched");
  a_idx0: assert property (p_idx0) else $error("no-offset indexed wrong");
  a_imm: assert property (p_imm) else $error("immediate operand wrong");
  a_dirShort: assert property (p_dirShort) else $error("short direct off page zero");
  a_longLen: assert property (p_longLen) else $error("long form length wrong");
  a_shortReach: assert property (p_shortReach) else $error("short indexed reach");
  a_pageZero: assert property (p_pageZero) else $error("page zero mode escaped");
  a_fetchPace: assert property (p_fetchPace) else $error("fetch pacing wrong");
  a_family: assert property (p_family) else $error("indirect family wrong");
endmodule // opaddr_props

bind operand_addr_decoder opaddr_props u_props (
  .mclk(mclk), .rst(rst), .start(start), .baseMode(baseMode), .prefixValid(prefixValid),
  .memRead(memRead), .memValid(memValid), .done(done), .busy(busy), .modeOut(modeOut),
  .familyOut(familyOut), .instLen(instLen), .effAddr(effAddr), .immValue(immValue),
  .isImmediate(isImmediate)
);

// file: sim/opaddr_mem.sv
`timescale 1ns/10ps
module opaddr_mem (
  input  wire logic        mclk,      // cpu clock
  input  wire logic        rst,       // sync reset
  input  wire logic        slow,      // answer late
  input  wire logic        memRead,   // read request
  input  wire logic [15:0] memAddr,   // read address
  output logic             memValid,  // read answer
  output logic [7:0]       memData    // read data
);
  logic [1:0]  count;
  logic [15:0] held;
  initial begin
    memValid = 1'b0;
    memData  = 8'h00;
    count    = 2'h0;
    held     = 16'h0000;
  end
  // content is low address byte plus 10h; data line flips once the answer has passed
  always @(posedge mclk) begin
    memValid <= 1'b0;
    if (memValid) memData <= ~memData;
    if (rst) count <= 2'h0;
    else if (count != 2'h0) begin
      count <= count - 2'h1;
      if (count == 2'h1) begin
        memValid <= 1'b1;
        memData  <= held[7:0] + 8'h10;
      end
    end else if (memRead && slow) begin
      held  <= memAddr;
      count <= 2'h3;
    end else if (memRead) begin
      memValid <= 1'b1;
      memData  <= memAddr[7:0] + 8'h10;
    end
  end
endmodule // opaddr_mem

// file: sim/test_operand_addr_decoder.sv
`timescale 1ns/10ps
module test_operand_addr_decoder;
  import opaddr_pkg::*;
  typedef struct {
    addr_mode_t m; logic [7:0] p; addr_mode_t em; mode_family_t f;
    logic [2:0] len; logic ce; logic [15:0] ea; logic [15:0] bt;
  } row_t;
  logic mclk, rst, start, prefixValid, rmwOp, memRead, memValid, done, busy, badMode;
  logic isImmediate, slow;
  logic [7:0] prefix, indexX, indexY, memData, immValue;
  logic [2:0] bitField, instLen, bitSel;
  logic [15:0] opcodePc, memAddr, effAddr, branchTarget;
  addr_mode_t baseMode, modeOut;
  mode_family_t familyOut;
  int mismatches, check_count;
  row_t rows [21] = '{
    '{M_INH, 8'h00, M_INH, F_INHERENT, 3'h0, 1'b0, 16'h0000, 16'h1271},
    '{M_IMM, 8'h00, M_IMM, F_IMMEDIATE, 3'h1, 1'b1, 16'h0081, 16'h1272},
    '{M_DIR_S, 8'h00, M_DIR_S, F_DIRECT, 3'h1, 1'b1, 16'h0081, 16'h1272},
    '{M_DIR_L, 8'h00, M_DIR_L, F_DIRECT, 3'h2, 1'b1, 16'h8182, 16'h1273},
    '{M_IDX_0, 8'h00, M_IDX_0, F_INDEXED, 3'h0, 1'b1, 16'h00f0, 16'h1271},
    '{M_IDX_0, 8'h90, M_IDX_0, F_INDEXED, 3'h0, 1'b1, 16'h0033, 16'h1271},
    '{M_IDX_S, 8'h00, M_IDX_S, F_INDEXED, 3'h1, 1'b1, 16'h0171, 16'h1272},
    '{M_IDX_S, 8'h90, M_IDX_S, F_INDEXED, 3'h1, 1'b1, 16'h00b4, 16'h1272},
    '{M_IDX_L, 8'h00, M_IDX_L, F_INDEXED, 3'h2, 1'b1, 16'h8272, 16'h1273},
    '{M_DIR_S, 8'h92, M_IND_S, F_INDIRECT, 3'h1, 1'b1, 16'h0091, 16'h1272},
    '{M_DIR_L, 8'h92, M_IND_L, F_INDIRECT, 3'h1, 1'b1, 16'h9192, 16'h1272},
    '{M_IDX_S, 8'h92, M_INDX_S, F_INDIRECT, 3'h1, 1'b1, 16'h0181, 16'h1272},
    '{M_IDX_L, 8'h92, M_INDX_L, F_INDIRECT, 3'h1, 1'b1, 16'h9282, 16'h1272},
    '{M_IDX_S, 8'h91, M_INDX_S, F_INDIRECT, 3'h1, 1'b1, 16'h00c4, 16'h1272},
    '{M_IDX_L, 8'h91, M_INDX_L, F_INDIRECT, 3'h1, 1'b1, 16'h91c5, 16'h1272},
    '{M_REL_D, 8'h00, M_REL_D, F_RELATIVE, 3'h1, 1'b0, 16'h0000, 16'h11f3},
    '{M_REL_D, 8'h92, M_REL_I, F_RELATIVE, 3'h1, 1'b0, 16'h0000, 16'h1203},
    '{M_BIT_D, 8'h00, M_BIT_D, F_BIT, 3'h1, 1'b1, 16'h0081, 16'h1272},
    '{M_BIT_D, 8'h92, M_BIT_I, F_BIT, 3'h1, 1'b1, 16'h0091, 16'h1272},
    '{M_BITREL_D, 8'h00, M_BITREL_D, F_BIT, 3'h2, 1'b1, 16'h0081, 16'h11f5},
    '{M_BITREL_D, 8'h92, M_BITREL_I, F_BIT, 3'h2, 1'b1, 16'h0091, 16'h11f5}
  };

  operand_addr_decoder uut (.*);
  opaddr_mem mem (.mclk(mclk), .rst(rst), .slow(slow), .memRead(memRead), .memAddr(memAddr),
                  .memValid(memValid), .memData(memData));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic close_out;
    if (mismatches == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // poke raises start again mid-decode; it must be ignored
  task automatic run(input addr_mode_t m, input logic [7:0] p, input logic rmw, input logic poke);
    @(posedge mclk);
    start <= 1'b1;
    baseMode <= m;
    prefixValid <= (p != 8'h00);
    prefix <= p;
    rmwOp <= rmw;
    @(posedge mclk);
    start <= 1'b0;
    if (poke) begin
      @(posedge mclk);
      start <= 1'b1;
      baseMode <= M_INH;
      @(posedge mclk);
      start <= 1'b0;
    end
    for (int k = 0; k < 40; k++) begin
      @(posedge mclk);
      #1;
      if (done === 1'b1) return;
    end
    mismatches++;
    close_out;
  endtask

  initial begin
    rst = 1'b1; start = 1'b0; baseMode = M_INH; prefixValid = 1'b0; prefix = 8'h00;
    rmwOp = 1'b0; bitField = 3'h0; opcodePc = 16'h1270; indexX = 8'hf0; indexY = 8'h33;
    slow = 1'b0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    cmp(modeOut, M_INH);
    cmp(effAddr, 16'h0000);
    cmp(busy, 1'b0);
    foreach (rows[i]) begin
      slow <= i[0];
      bitField <= i[2:0];
      run(rows[i].m, rows[i].p, 1'b0, 1'b0);
      cmp(modeOut, rows[i].em);
      cmp(familyOut, rows[i].f);
      cmp(instLen, rows[i].len);
      if (rows[i].ce) cmp(effAddr, rows[i].ea);
      cmp(branchTarget, rows[i].bt);
      cmp(badMode, 1'b0);
      if (rows[i].f == F_BIT) cmp(bitSel, i[2:0]);
      if (rows[i].em == M_IMM) cmp({isImmediate, immValue}, 9'h181);
      if (rows[i].em != M_IMM) cmp(isImmediate, 1'b0);
    end
    run(M_DIR_L, 8'h00, 1'b1, 1'b0);
    cmp(badMode, 1'b1);
    run(M_DIR_S, 8'h00, 1'b1, 1'b0);
    cmp(badMode, 1'b0);
    run(M_DIR_L, 8'h92, 1'b1, 1'b0);
    cmp(badMode, 1'b1);
    run(M_DIR_S, 8'h91, 1'b0, 1'b0);
    cmp(badMode, 1'b1);
    slow <= 1'b1;
    run(M_DIR_L, 8'h00, 1'b0, 1'b1);
    cmp(modeOut, M_DIR_L);
    cmp(effAddr, 16'h8182);
    // reset in the middle of a slow long fetch
    @(posedge mclk);
    start <= 1'b1;
    baseMode <= M_DIR_L;
    @(posedge mclk);
    start <= 1'b0;
    repeat (3) @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    cmp({done, busy}, 2'h0);
    cmp(effAddr, 16'h0000);
    slow <= 1'b0;
    run(M_IDX_S, 8'h00, 1'b0, 1'b0);
    cmp(effAddr, 16'h0171);
    close_out;
  end
endmodule // test_operand_addr_decoder
